// *** logic/amfs_frame_sequencer.sv ***
// amfs_frame_sequencer: top of the adc multiplexer frame sequencer
// assumes: slow tick clock sampled as a level synchronous to core_clk_i
`timescale 1ns/1ps
module amfs_frame_sequencer
    import amfs_pkg::*;
#(
    parameter int SAMPLE_W = 24
)
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic slow_tick_clock_i,
    input wire logic low_power_sleep_i,
    input wire logic [AMFS_NUM_REMOTE-1:0] remote_sample_valid_i,
    input wire logic [AMFS_NUM_REMOTE*SAMPLE_W-1:0] remote_sample_data_i,
    output logic [3:0] mux_select_o,
    output logic mux_advance_o,
    output logic filter_start_o,
    output logic ce_launch_o,
    output logic reference_chop_phase_o,
    output logic [3:0] slot_index_o,
    output logic second_half_o,
    output logic fast_pll_select_o,
    output logic converter_clock_divide_o,
    output logic [1:0] filter_length_select_o,
    output logic [3:0] differential_enable_o,
    output logic [AMFS_NUM_REMOTE-1:0] remote_sensor_enable_o,
    output logic [AMFS_FRAME_W-1:0] frame_length_o,
    output logic [AMFS_FIR_W-1:0] frame_length_fir_o,
    output logic ram_we_o,
    output logic [AMFS_RAM_ADDR_W-1:0] ram_addr_o,
    output logic [SAMPLE_W-1:0] ram_data_o
);

    typedef struct packed {
        amfs_state_t st;
        logic [AMFS_NUM_SLOT_REGS-1:0][7:0] slot_reg;
        logic [7:0] chop_reg;
        logic [7:0] filt_reg;
        logic [7:0] clk_reg;
        logic [7:0] rmt_reg;
        logic tick_q;
        logic [AMFS_FRAME_W-1:0] frame_pos;
        logic [AMFS_SLOT_LEN_W-1:0] slot_tick;
        logic [1:0] gap_tick;
        logic [3:0] slot_idx;
        logic [3:0] mux_sel;
        logic mux_adv;
        logic filt_start;
        logic ce_launch;
        logic chop_phase;
        logic second_half;
        logic [7:0] rdata;
    } amfs_seq_t;

    amfs_seq_t s;
    amfs_seq_t next_s;

    logic [AMFS_SLOT_LEN_W-1:0] slot_len;
    logic [1:0] gap_len;
    logic [AMFS_FRAME_W-1:0] frame_len;
    logic [3:0] spf_raw;
    logic [3:0] spf;
    logic [1:0] fls;
    logic div_bit;
    logic fast_bit;
    logic [AMFS_NUM_REMOTE-1:0] rmt_en;
    amfs_chop_t chop_mode;

    // ==================================================================
    // configuration fields
    assign spf_raw = s.slot_reg[0][AMFS_SPF_LSB +: AMFS_NIBBLE];
    assign spf = (spf_raw > AMFS_MAX_SLOTS) ? AMFS_MAX_SLOTS : spf_raw;
    assign fls = s.filt_reg[AMFS_FLS_LSB +: 2];
    assign div_bit = s.clk_reg[AMFS_DIV_BIT];
    assign fast_bit = s.clk_reg[AMFS_FAST_BIT];
    assign rmt_en = s.rmt_reg[AMFS_RMT_LSB +: AMFS_NUM_REMOTE];
    assign chop_mode = amfs_chop_t'(s.chop_reg[AMFS_CHOP_LSB +: 2]);

    // ==================================================================
    // slot and frame lengths
    amfs_timing u_timing (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .filter_length_select_i(fls),
        .converter_clock_divide_i(div_bit),
        .fast_pll_select_i(fast_bit),
        .slots_i(spf),
        .slot_len_o(slot_len),
        .gap_len_o(gap_len),
        .frame_len_o(frame_len),
        .frame_fir_o(frame_length_fir_o)
    );

    // ==================================================================
    // remote current samples into engine ram
    amfs_remote_writer #(
        .SAMPLE_W(SAMPLE_W),
        .NUM(AMFS_NUM_REMOTE)
    ) u_remote (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .second_half_i(s.second_half),
        .remote_sensor_enable_i(rmt_en),
        .sample_valid_i(remote_sample_valid_i),
        .sample_data_i(remote_sample_data_i),
        .ram_we_o(ram_we_o),
        .ram_addr_o(ram_addr_o),
        .ram_data_o(ram_data_o)
    );

    // ==================================================================
    // slot select lookup: slot n sits in byte 5-n/2, nibble n%2
    function automatic logic [3:0] amfs_slot_sel(
        input logic [AMFS_NUM_SLOT_REGS-1:0][7:0] regs,
        input logic [3:0] n
    );
        logic [2:0] byte_idx;
        byte_idx = 3'(AMFS_NUM_SLOT_REGS - 1) - 3'(n >> 1);
        if (n[0]) begin
            amfs_slot_sel = regs[byte_idx][AMFS_NIBBLE +: AMFS_NIBBLE];
        end else begin
            amfs_slot_sel = regs[byte_idx][0 +: AMFS_NIBBLE];
        end
    endfunction : amfs_slot_sel

    // ==================================================================
    // next state
    always_comb begin
        logic tick;
        logic run;
        logic do_frame;
        logic do_slot;
        logic [3:0] nxt_idx;
        logic [2:0] widx;
        logic [7:0] rd_val;
        next_s = s;
        tick = slow_tick_clock_i & ~s.tick_q;
        run = (spf != 4'h0);
        do_frame = 1'b0;
        do_slot = 1'b0;
        nxt_idx = 4'h0;
        widx = 3'(addr_i - AMFS_SLOT_BASE);
        rd_val = AMFS_UNMAPPED;
        next_s.tick_q = slow_tick_clock_i;
        next_s.mux_adv = 1'b0;
        next_s.filt_start = 1'b0;
        next_s.ce_launch = 1'b0;

        // sequencer
        if (!run) begin
            next_s.st = AMFS_IDLE;
            next_s.frame_pos = '0;
            next_s.slot_idx = 4'h0;
            next_s.slot_tick = '0;
            next_s.gap_tick = 2'h0;
        end else if (tick) begin
            case (s.st)
                AMFS_IDLE: begin
                    do_frame = 1'b1;
                end
                AMFS_GAP: begin
                    next_s.frame_pos = AMFS_FRAME_W'(s.frame_pos + 1'b1);
                    if (2'(s.gap_tick + 1'b1) >= gap_len) begin
                        do_slot = 1'b1;
                        nxt_idx = 4'h0;
                    end else begin
                        next_s.gap_tick = 2'(s.gap_tick + 1'b1);
                    end
                end
                AMFS_SLOT: begin
                    next_s.frame_pos = AMFS_FRAME_W'(s.frame_pos + 1'b1);
                    if (AMFS_SLOT_LEN_W'(s.slot_tick + 1'b1) >= slot_len) begin
                        if (4'(s.slot_idx + 1'b1) >= spf) begin
                            do_frame = 1'b1;
                        end else begin
                            do_slot = 1'b1;
                            nxt_idx = 4'(s.slot_idx + 1'b1);
                        end
                    end else begin
                        next_s.slot_tick = AMFS_SLOT_LEN_W'(s.slot_tick + 1'b1);
                    end
                end
                default: begin
                    next_s.st = AMFS_IDLE;
                end
            endcase
        end

        if (do_frame) begin
            next_s.st = AMFS_GAP;
            next_s.gap_tick = 2'h0;
            next_s.frame_pos = '0;
            next_s.ce_launch = 1'b1;
            case (chop_mode)
                AMFS_CHOP_OFF: next_s.chop_phase = 1'b0;
                AMFS_CHOP_HIGH: next_s.chop_phase = 1'b1;
                AMFS_CHOP_LOW: next_s.chop_phase = 1'b0;
                AMFS_CHOP_TOGGLE: next_s.chop_phase = ~s.chop_phase;
                default: next_s.chop_phase = 1'b0;
            endcase
        end
        if (do_slot) begin
            next_s.st = AMFS_SLOT;
            next_s.slot_tick = '0;
            next_s.slot_idx = nxt_idx;
            next_s.mux_sel = amfs_slot_sel(s.slot_reg, nxt_idx);
            next_s.mux_adv = 1'b1;
            next_s.filt_start = 1'b1;
        end
        next_s.second_half = run && (next_s.st != AMFS_IDLE)
                           && (next_s.frame_pos >= (frame_len >> 1));

        // register writes
        if (wr_i) begin
            if (addr_i >= AMFS_SLOT_BASE && addr_i <= AMFS_SLOT_LAST) begin
                next_s.slot_reg[widx] = wdata_i;
            end else if (addr_i == AMFS_CHOP_ADDR) begin
                next_s.chop_reg = wdata_i;
            end else if (addr_i == AMFS_FILT_ADDR) begin
                next_s.filt_reg = wdata_i;
            end else if (addr_i == AMFS_CLK_ADDR) begin
                next_s.clk_reg = wdata_i;
            end else if (addr_i == AMFS_RMT_ADDR) begin
                next_s.rmt_reg = wdata_i;
            end
        end

        // sleep returns every configuration register to zero
        if (low_power_sleep_i) begin
            next_s.slot_reg = '0;
            next_s.chop_reg = AMFS_CFG_RESET;
            next_s.filt_reg = AMFS_CFG_RESET;
            next_s.clk_reg = AMFS_CFG_RESET;
            next_s.rmt_reg = AMFS_CFG_RESET;
        end

        // register reads, data in the following cycle only
        if (addr_i >= AMFS_SLOT_BASE && addr_i <= AMFS_SLOT_LAST) begin
            rd_val = s.slot_reg[widx];
        end else if (addr_i == AMFS_CHOP_ADDR) begin
            rd_val = s.chop_reg;
        end else if (addr_i == AMFS_FILT_ADDR) begin
            rd_val = s.filt_reg;
        end else if (addr_i == AMFS_CLK_ADDR) begin
            rd_val = s.clk_reg;
        end else if (addr_i == AMFS_RMT_ADDR) begin
            rd_val = s.rmt_reg;
        end else if (addr_i == AMFS_STAT_ADDR) begin
            rd_val[AMFS_NIBBLE-1:0] = s.slot_idx;
            rd_val[AMFS_STAT_RUN_BIT] = (s.st != AMFS_IDLE);
            rd_val[AMFS_STAT_CHOP_BIT] = s.chop_phase;
            rd_val[AMFS_STAT_HALF_BIT] = s.second_half;
        end
        next_s.rdata = rd_i ? rd_val : AMFS_UNMAPPED;
    end

    // ==================================================================
    // state register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
            s.st <= AMFS_IDLE;
        end else if (clk_en_i) begin
            s <= next_s;
        end
    end

    // ==================================================================
    // outputs
    assign rdata_o = s.rdata;
    assign mux_select_o = s.mux_sel;
    assign mux_advance_o = s.mux_adv;
    assign filter_start_o = s.filt_start;
    assign ce_launch_o = s.ce_launch;
    assign reference_chop_phase_o = s.chop_phase;
    assign slot_index_o = s.slot_idx;
    assign second_half_o = s.second_half;
    assign fast_pll_select_o = fast_bit;
    assign converter_clock_divide_o = div_bit;
    assign filter_length_select_o = fls;
    assign differential_enable_o = s.filt_reg[AMFS_DIFF_LSB +: 4];
    assign remote_sensor_enable_o = rmt_en;
    assign frame_length_o = frame_len;

endmodule : amfs_frame_sequencer

// *** common/amfs_pkg.sv ***
// amfs_pkg: constants, field layout and types of the adc mux frame sequencer
// assumes: byte-wide register port with 16-bit addresses, one core clock
package amfs_pkg;

    // ==================================================================
    // register offsets
    localparam logic [15:0] AMFS_SLOT_BASE = 16'h2100;
    localparam logic [15:0] AMFS_SLOT_LAST = 16'h2105;
    localparam logic [15:0] AMFS_CHOP_ADDR = 16'h2106;
    localparam logic [15:0] AMFS_FILT_ADDR = 16'h210C;
    localparam logic [15:0] AMFS_CLK_ADDR = 16'h2200;
    localparam logic [15:0] AMFS_RMT_ADDR = 16'h2709;
    localparam logic [15:0] AMFS_STAT_ADDR = 16'h21F0;

    // ==================================================================
    // field positions and reset values
    localparam int AMFS_NIBBLE = 4;
    localparam int AMFS_SPF_LSB = 4;
    localparam int AMFS_CHOP_LSB = 2;
    localparam int AMFS_FLS_LSB = 1;
    localparam int AMFS_DIFF_LSB = 4;
    localparam int AMFS_DIV_BIT = 5;
    localparam int AMFS_FAST_BIT = 4;
    localparam int AMFS_RMT_LSB = 3;
    localparam int AMFS_STAT_RUN_BIT = 4;
    localparam int AMFS_STAT_CHOP_BIT = 5;
    localparam int AMFS_STAT_HALF_BIT = 6;
    localparam logic [7:0] AMFS_CFG_RESET = 8'h00;
    localparam logic [7:0] AMFS_UNMAPPED = 8'h00;

    // ==================================================================
    // widths and timing constants
    localparam int AMFS_NUM_SLOT_REGS = 6;
    localparam logic [3:0] AMFS_MAX_SLOTS = 4'hB;
    localparam int AMFS_NUM_REMOTE = 3;
    localparam int AMFS_SLOT_LEN_W = 5;
    localparam int AMFS_FRAME_W = 9;
    localparam int AMFS_FIR_W = 16;
    localparam int AMFS_RAM_ADDR_W = 8;
    localparam logic [7:0] AMFS_REMOTE_RAM_BASE = 8'h10;
    localparam logic [4:0] AMFS_SLOW_PLL_MULT = 5'h03;
    localparam logic [1:0] AMFS_GAP_BASE = 2'h3;
    localparam logic [1:0] AMFS_GAP_FAST_SUB = 2'h2;
    localparam logic [7:0] AMFS_FIR_BASE = 8'h30;
    localparam logic [7:0] AMFS_FIR_FAST_ADD = 8'h66;
    localparam int AMFS_SLOW_CLOCK_HZ = 32768;
    localparam int AMFS_CORE_CLOCK_HZ = 10000000;

    // ==================================================================
    // types
    typedef enum logic [2:0] {
        AMFS_IDLE = 3'b001,
        AMFS_GAP = 3'b010,
        AMFS_SLOT = 3'b100
    } amfs_state_t;

    typedef enum logic [1:0] {
        AMFS_CHOP_OFF = 2'h0,
        AMFS_CHOP_HIGH = 2'h1,
        AMFS_CHOP_LOW = 2'h2,
        AMFS_CHOP_TOGGLE = 2'h3
    } amfs_chop_t;

endpackage : amfs_pkg

// *** logic/amfs_timing.sv ***
// amfs_timing: slot, gap and frame lengths from the converter settings
// assumes: settings change only while the frame sequencer is stopped
`timescale 1ns/1ps
module amfs_timing
    import amfs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic [1:0] filter_length_select_i,
    input wire logic converter_clock_divide_i,
    input wire logic fast_pll_select_i,
    input wire logic [3:0] slots_i,
    output logic [AMFS_SLOT_LEN_W-1:0] slot_len_o,
    output logic [1:0] gap_len_o,
    output logic [AMFS_FRAME_W-1:0] frame_len_o,
    output logic [AMFS_FIR_W-1:0] frame_fir_o
);

    typedef struct packed {
        logic [AMFS_SLOT_LEN_W-1:0] slot_len;
        logic [1:0] gap_len;
        logic [AMFS_FRAME_W-1:0] frame_len;
        logic [AMFS_FIR_W-1:0] frame_fir;
    } amfs_tim_t;

    amfs_tim_t s;
    amfs_tim_t next_s;

    // ==================================================================
    // length arithmetic
    always_comb begin
        logic [AMFS_SLOT_LEN_W-1:0] prod;
        logic [7:0] fir_mult;
        prod = AMFS_SLOT_LEN_W'((filter_length_select_i + 3'h1)
                                * (converter_clock_divide_i + 2'h1));
        next_s.slot_len = fast_pll_select_i ? prod
                        : AMFS_SLOT_LEN_W'(AMFS_SLOW_PLL_MULT * prod);
        next_s.gap_len = fast_pll_select_i ? 2'(AMFS_GAP_BASE - AMFS_GAP_FAST_SUB)
                       : AMFS_GAP_BASE;
        next_s.frame_len = AMFS_FRAME_W'(next_s.gap_len
                         + next_s.slot_len * slots_i);
        fir_mult = fast_pll_select_i ? 8'(AMFS_FIR_BASE + AMFS_FIR_FAST_ADD)
                 : AMFS_FIR_BASE;
        next_s.frame_fir = AMFS_FIR_W'(next_s.frame_len * fir_mult);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else if (clk_en_i) begin
            s <= next_s;
        end
    end

    assign slot_len_o = s.slot_len;
    assign gap_len_o = s.gap_len;
    assign frame_len_o = s.frame_len;
    assign frame_fir_o = s.frame_fir;

endmodule : amfs_timing

// *** logic/amfs_remote_writer.sv ***
// amfs_remote_writer: stores remote current samples straight into compute-engine ram
// assumes: each remote interface gives a one-cycle valid with its sample
`timescale 1ns/1ps
module amfs_remote_writer
    import amfs_pkg::*;
#(
    parameter int SAMPLE_W = 24,
    parameter int NUM = AMFS_NUM_REMOTE
)
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic second_half_i,
    input wire logic [NUM-1:0] remote_sensor_enable_i,
    input wire logic [NUM-1:0] sample_valid_i,
    input wire logic [NUM*SAMPLE_W-1:0] sample_data_i,
    output logic ram_we_o,
    output logic [AMFS_RAM_ADDR_W-1:0] ram_addr_o,
    output logic [SAMPLE_W-1:0] ram_data_o
);

    typedef struct packed {
        logic [NUM-1:0] pending;
        logic [NUM-1:0][SAMPLE_W-1:0] data;
        logic we;
        logic [AMFS_RAM_ADDR_W-1:0] addr;
        logic [SAMPLE_W-1:0] wdata;
    } amfs_rw_t;

    amfs_rw_t s;
    amfs_rw_t next_s;
    logic [NUM-1:0] capture;

    // ==================================================================
    // per-pair capture
    for (genvar g = 0; g < NUM; g++) begin : g_cap
        assign capture[g] = sample_valid_i[g] & remote_sensor_enable_i[g];
    end

    // ==================================================================
    // one write per cycle, lowest pair first, only in the second half
    always_comb begin
        logic [NUM-1:0] grant;
        logic found;
        grant = '0;
        found = 1'b0;
        next_s = s;
        next_s.we = 1'b0;
        for (int i = 0; i < NUM; i++) begin
            if (second_half_i && s.pending[i] && !found) begin
                grant[i] = 1'b1;
                found = 1'b1;
                next_s.we = 1'b1;
                next_s.addr = AMFS_RAM_ADDR_W'(AMFS_REMOTE_RAM_BASE + i);
                next_s.wdata = s.data[i];
            end
        end
        for (int i = 0; i < NUM; i++) begin
            if (capture[i]) begin
                next_s.data[i] = sample_data_i[i*SAMPLE_W +: SAMPLE_W];
            end
        end
        next_s.pending = (s.pending & ~grant & remote_sensor_enable_i) | capture;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else if (clk_en_i) begin
            s <= next_s;
        end
    end

    assign ram_we_o = s.we;
    assign ram_addr_o = s.addr;
    assign ram_data_o = s.wdata;

endmodule : amfs_remote_writer

// *** sim/amfs_checker.sv ***
// amfs_checker: port assertions on the frame sequencer top
// assumes: clk_en_i held high, one core clock domain
`timescale 1ns/1ps
module amfs_checker
    import amfs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic slow_tick_clock_i,
    input wire logic mux_advance_o,
    input wire logic filter_start_o,
    input wire logic ce_launch_o,
    input wire logic [3:0] slot_index_o,
    input wire logic second_half_o,
    input wire logic ram_we_o,
    input wire logic [AMFS_RAM_ADDR_W-1:0] ram_addr_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // ====================================
    // assertions
    chk_filter_with_adv: assert property (filter_start_o == mux_advance_o)
        else $error("filter start apart from mux advance");
    chk_launch_one_pulse: assert property (ce_launch_o |=> !ce_launch_o)
        else $error("engine launch longer than one cycle");
    chk_adv_on_tick: assert property (mux_advance_o |-> $past(slow_tick_clock_i) && !$past(slow_tick_clock_i, 2))
        else $error("mux advance without a slow tick edge");
    chk_launch_on_tick: assert property (ce_launch_o |-> $past(slow_tick_clock_i) && !$past(slow_tick_clock_i, 2))
        else $error("engine launch without a slow tick edge");
    chk_gap_first: assert property (ce_launch_o |-> !mux_advance_o ##1 !mux_advance_o)
        else $error("slot started inside the frame gap");
    chk_slot_max: assert property (slot_index_o < 4'hB)
        else $error("slot index beyond eleven slots");
    chk_remote_half: assert property (ram_we_o |-> $past(second_half_o))
        else $error("remote write outside second half");
    chk_remote_addr: assert property (ram_we_o |-> ram_addr_o inside {8'h10, 8'h11, 8'h12})
        else $error("remote write to a wrong ram place");
    chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside the answer cycle");
    cov_launch: cover property (ce_launch_o);
    cov_advance: cover property (mux_advance_o);
    cov_remote: cover property (ram_we_o);
endmodule : amfs_checker
bind amfs_frame_sequencer amfs_checker i_amfs_checker (.core_clk_i, .resetn_i, .rd_i, .rdata_o,
    .slow_tick_clock_i, .mux_advance_o, .filter_start_o, .ce_launch_o, .slot_index_o,
    .second_half_o, .ram_we_o, .ram_addr_o);

// *** sim/amfs_far_model.sv ***
// amfs_far_model: slow tick source and per-frame conversion count of the converter side
// assumes: one core clock, tick period of 2*TICK_HALF core cycles
`timescale 1ns/1ps
module amfs_far_model #(
    parameter int TICK_HALF = 4
)
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic mux_advance_i,
    input wire logic ce_launch_i,
    output logic slow_tick_clock_o,
    output logic [3:0] frame_slots_o
);
    int cnt;
    logic [3:0] adv;
    // ====================================
    // free running slow clock, conversions counted per frame
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= 0;
            adv <= 4'h0;
            slow_tick_clock_o <= 1'b0;
            frame_slots_o <= 4'h0;
        end else begin
            cnt <= (cnt == TICK_HALF - 1) ? 0 : cnt + 1;
            if (cnt == TICK_HALF - 1) slow_tick_clock_o <= ~slow_tick_clock_o;
            if (ce_launch_i) begin
                frame_slots_o <= adv;
                adv <= 4'h0;
            end else if (mux_advance_i) adv <= adv + 4'h1;
        end
    end
endmodule : amfs_far_model

// *** sim/amfs_frame_sequencer_test.sv ***
// amfs_frame_sequencer_test: self-checking bench of the frame sequencer
// assumes: far model makes the slow tick, clock enable held high
`timescale 1ns/1ps
module amfs_frame_sequencer_test
    import amfs_pkg::*;
;
    localparam int P = 8;
    logic core_clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic low_power_sleep_i = 1'b0, rd_d = 1'b0, watch = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00, rdata_o, ram_addr_o, gap = 8'h00;
    logic [2:0] remote_sample_valid_i = 3'h0;
    logic [71:0] remote_sample_data_i = 72'h0;
    logic slow_tick_clock_i, mux_advance_o, filter_start_o, ce_launch_o, reference_chop_phase_o;
    logic second_half_o, ram_we_o;
    logic [3:0] mux_select_o, slot_index_o, frame_slots;
    logic [10:0] cfg;
    logic [8:0] frame_length_o;
    logic [15:0] frame_length_fir_o;
    logic [23:0] ram_data_o;
    logic [31:0] seed = 32'hA515, d, e, rd_q[$], ram_q[$], ev_q[$];
    logic [15:0] adr [12] = '{16'h2100, 16'h2101, 16'h2102, 16'h2103, 16'h2104, 16'h2105,
        16'h2106, 16'h210C, 16'h2200, 16'h2709, 16'h21F0, 16'h2300};
    int n_errors = 0, cmp_count = 0, cycles = 0, sl, fr, s;
    amfs_frame_sequencer i_amfs_frame_sequencer (.core_clk_i, .resetn_i, .clk_en_i(1'b1),
        .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .slow_tick_clock_i, .low_power_sleep_i,
        .remote_sample_valid_i, .remote_sample_data_i, .mux_select_o, .mux_advance_o,
        .filter_start_o, .ce_launch_o, .reference_chop_phase_o, .slot_index_o, .second_half_o,
        .fast_pll_select_o(cfg[10]), .converter_clock_divide_o(cfg[9]),
        .filter_length_select_o(cfg[8:7]), .differential_enable_o(cfg[6:3]),
        .remote_sensor_enable_o(cfg[2:0]), .frame_length_o,
        .frame_length_fir_o, .ram_we_o, .ram_addr_o, .ram_data_o);
    amfs_far_model #(.TICK_HALF(P / 2)) i_amfs_far_model (.core_clk_i, .resetn_i,
        .mux_advance_i(mux_advance_o), .ce_launch_i(ce_launch_o),
        .slow_tick_clock_o(slow_tick_clock_i), .frame_slots_o(frame_slots));
    always #50 core_clk_i = ~core_clk_i;
    // ====================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [31:0] pop(ref logic [31:0] q[$]);
        if (q.size() == 0) return 32'hFFFFFFFF;
        return q.pop_front();
    endfunction : pop
    task automatic check(input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            n_errors++;
            $display("Error at %0t: expected %h got %h", $time, ex, got);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        rd_q.push_back({24'h0, v});
        @(posedge core_clk_i);
        rd_i <= 1'b0;
    endtask : rd
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // ====================================
    // result watcher and timeout
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
        if (rd_d) check(pop(rd_q), {24'h0, rdata_o});
        rd_d <= rd_i;
        if (ram_we_o) check(pop(ram_q), {ram_addr_o, ram_data_o});
        gap <= gap + 8'h01;
        if (mux_advance_o || ce_launch_o) begin
            gap <= 8'h01;
            e = watch ? pop(ev_q) : 32'h0;
            if (watch) check(e, {19'h0, ce_launch_o, mux_select_o, e[7:0] == 8'h00 ? 8'h00 : gap});
        end
    end
    // ====================================
    // stimulus
    initial begin
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (int ph = 0; ph < 3; ph++) begin
            if (ph == 2) begin
                @(posedge core_clk_i);
                low_power_sleep_i <= 1'b1;
                @(posedge core_clk_i);
                low_power_sleep_i <= 1'b0;
            end
            foreach (adr[i]) begin
                d = xs();
                if (i == 0) d[7:4] = 4'h0;
                if (ph == 1) wr(adr[i], d[7:0]);
                rd(adr[i], (ph == 1 && i < 10) ? d[7:0] : 8'h00);
            end
        end
        for (int k = 0; k < 16; k++) begin
            d = xs();
            s = 32'(d[3:0] | 4'h1);
            wr(AMFS_SLOT_BASE, 8'h00);
            wr(AMFS_CLK_ADDR, 8'((k / 8) * 32 + (k % 2) * 16));
            wr(AMFS_FILT_ADDR, 8'hF0 | 8'(((k / 2) % 4) * 2));
            wr(AMFS_SLOT_BASE, 8'(s * 16));
            repeat (3) @(posedge core_clk_i);
            sl = ((k / 2) % 4 + 1) * (k / 8 + 1) * ((k % 2) == 1 ? 1 : 3);
            fr = 3 - 2 * (k % 2) + sl * (s > 11 ? 11 : s);
            check(fr, {23'h0, frame_length_o});
            check(fr * (48 + 102 * (k % 2)), {16'h0, frame_length_fir_o});
            check({21'h0, k % 2 == 1, k > 7, 2'(k / 2 % 4), 7'h78}, {21'h0, cfg});
        end
        wr(AMFS_SLOT_BASE, 8'h00);
        wr(AMFS_CLK_ADDR, 8'h30);
        wr(AMFS_FILT_ADDR, 8'h10);
        wr(AMFS_CHOP_ADDR, 8'h04);
        wr(AMFS_SLOT_LAST, 8'h98);
        wr(16'h2104, 8'h0A);
        wr(AMFS_RMT_ADDR, 8'h38);
        for (int f = 0; f < 2; f++) begin
            ev_q.push_back({19'h0, 1'b1, f == 1 ? {4'hA, 8'(2 * P)} : 12'h000});
            ev_q.push_back({19'h0, 1'b0, 4'h8, 8'(P)});
            ev_q.push_back({19'h0, 1'b0, 4'h9, 8'(2 * P)});
            ev_q.push_back({19'h0, 1'b0, 4'hA, 8'(2 * P)});
        end
        d = xs();
        ram_q.push_back({8'h10, ~d[23:0]});
        ram_q.push_back({8'h12, d[23:0]});
        watch = 1'b1;
        wr(AMFS_SLOT_BASE, 8'h30);
        remote_sample_valid_i <= 3'b101;
        remote_sample_data_i <= {d[23:0], 24'h0, ~d[23:0]};
        @(posedge core_clk_i);
        remote_sample_valid_i <= 3'h0;
        remote_sample_data_i <= ~remote_sample_data_i;
        for (int i = 0; i < 400 && ev_q.size() > 0; i++) @(posedge core_clk_i);
        check(32'h0, 32'(ev_q.size() + ram_q.size()));
        check(32'h1, {31'h0, reference_chop_phase_o});
        check(32'h3, {28'h0, frame_slots});
        wr(AMFS_SLOT_BASE, 8'h00);
        repeat (10 * P) @(posedge core_clk_i);
        tally_and_finish();
    end
endmodule : amfs_frame_sequencer_test
